/* File: asc_ctrl_props.sv */
// Purpose: port assertions for the standby control block
// Assumes: one clock domain, async pins synced in about 3 cycles
// Notes: windows of 5 cycles leave room for the sync chain
`timescale 1ns/1ps
module asc_ctrl_props
    import asc_pkg::*;
#(
    parameter int EN_W = 4,
    parameter int SAMPLE_W = 32
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [EN_W-1:0] enable_pins_i,
    input wire logic pll_locked_i,
    input wire logic mute_n_i,
    input wire logic fault_open_load_i,
    input wire logic fault_short_i,
    input wire logic fault_thermal_i,
    input wire asc_pkg::asc_state_t state_o,
    input wire logic [6:0] slave_addr_o,
    input wire logic slave_en_o,
    input wire logic regs_default_o,
    input wire logic amp_reset_o,
    input wire logic diag_irq_n_o,
    input wire logic muted_o,
    input wire logic [SAMPLE_W-1:0] sample_o,
    input wire logic sample_valid_o,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o
);
    wire flt = fault_open_load_i | fault_short_i | fault_thermal_i;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    chk_never_master: assert property (!scl_oe_o && !sda_oe_o)
        else $error("bus driven as master");
    chk_standby_held: assert property (state_o == ASC_STANDBY |-> amp_reset_o && !slave_en_o)
        else $error("standby without amp reset");
    chk_slave_gate: assert property (slave_en_o |-> state_o == ASC_ACTIVE && slave_addr_o[6:3] == 4'hd)
        else $error("slave enabled out of active");
    chk_enables_low: assert property ((enable_pins_i == 0) [*5] |-> state_o == ASC_STANDBY && amp_reset_o)
        else $error("enables low but not in standby");
    chk_enable_cause: assert property (slave_en_o |-> $past(enable_pins_i != 0, 4))
        else $error("slave enabled without enables");
    chk_lock_lost: assert property (!pll_locked_i [*5] |-> !slave_en_o && amp_reset_o)
        else $error("running without lock");
    chk_regs_default: assert property ($rose(slave_en_o) |-> regs_default_o)
        else $error("registers not at default on enable");
    chk_fault_irq: assert property (flt [*5] |-> !diag_irq_n_o)
        else $error("fault without interrupt");
    chk_irq_quiet: assert property (!flt [*5] |-> diag_irq_n_o)
        else $error("interrupt without fault");
    chk_mute_pin: assert property (!mute_n_i [*5] |-> muted_o)
        else $error("mute pin ignored");
    chk_mute_zero: assert property (sample_valid_o && muted_o |-> sample_o == '0)
        else $error("sample nonzero while muted");
    cov_active: cover property ($rose(slave_en_o));
    cov_irq: cover property ($fell(diag_irq_n_o));
    cov_play: cover property (sample_valid_o && !muted_o);
endmodule // asc_ctrl_props

bind asc_standby_ctrl asc_ctrl_props #(.EN_W(EN_W), .SAMPLE_W(SAMPLE_W))
    asc_ctrl_props_i (.clk_sys_i, .reset_i, .enable_pins_i, .pll_locked_i,
    .mute_n_i, .fault_open_load_i, .fault_short_i, .fault_thermal_i,
    .state_o, .slave_addr_o, .slave_en_o, .regs_default_o, .amp_reset_o,
    .diag_irq_n_o, .muted_o, .sample_o, .sample_valid_o, .scl_oe_o,
    .sda_oe_o);

/* File: asc_defs.svh */
// Purpose: constants for the amplifier standby control block
// Assumes: 100 MHz system clock
// Notes: counts derived from times by integer division, rounding down
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
`define ASC_CLK_PERIOD_NS 10
`define ASC_BCLK_TIMEOUT_NS 2000
`define ASC_BCLK_TIMEOUT_CYC ((`ASC_BCLK_TIMEOUT_NS) / (`ASC_CLK_PERIOD_NS))
`define ASC_WS_TIMEOUT_BCLK 128
`define ASC_LOCK_SETTLE_CYC 16
`define ASC_ADDR_BASE 7'h68
`define ASC_EN_WIDTH 4
`define ASC_FIFO_DEPTH 8
`define ASC_SAMPLE_W 32
`endif

/* File: asc_fifo.sv */
// Purpose: sample FIFO between link capture and amplifier output
// Assumes: one clock, synchronous flush
// Notes: depth must be a power of two
`timescale 1ns/1ps
module asc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } asc_fifo_st_t;
    asc_fifo_st_t s_q, s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full, empty, push, pop;

    assign empty = (s_q.wr == s_q.rd);
    assign full = (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]) && !empty;
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[s_q.rd[AW-1:0]];

    always_comb begin
        s_d = s_q;
        if (flush_i) begin
            s_d.wr = '0;
            s_d.rd = '0;
        end else begin
            if (push) s_d.wr = s_q.wr + 1'b1;
            if (pop) s_d.rd = s_q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (push && !flush_i) begin
            mem[s_q.wr[AW-1:0]] <= in_data_i;
        end
    end
endmodule // asc_fifo

/* File: asc_link_src.sv */
// Purpose: serial audio source standing in for the host controller
// Assumes: 125 ns bit clock, 32-bit frames, word select low half first
// Notes: run is only looked at between frames
`timescale 1ns/1ps
module asc_link_src (
    input wire logic run_i,
    output logic bclk_o,
    output logic ws_o,
    output logic sd_o
);
    logic [31:0] word = 32'h0;
    initial begin
        bclk_o = 0;
        ws_o = 0;
        sd_o = 0;
        #37;
        forever begin
            if (!run_i) begin
                // Clock stands still; released data line keeps moving
                sd_o = ~sd_o;
                #62.5;
            end else begin
                word = word + 32'h01234567;
                for (int i = 31; i >= 0; i--) begin
                    ws_o = (i < 16);
                    sd_o = word[i];
                    #62.5 bclk_o = 1;
                    #62.5 bclk_o = 0;
                end
            end
        end
    end
endmodule // asc_link_src

/* File: asc_pkg.sv */
// Purpose: types for the amplifier standby control block
// Assumes: nothing
// Notes: state machine states only
package asc_pkg;
    typedef enum logic [2:0] {
        ASC_STANDBY,
        ASC_WAIT_LINK,
        ASC_LOCKING,
        ASC_ACTIVE
    } asc_state_t;
endpackage

/* File: asc_standby_ctrl.sv */
// Purpose: standby and reset control state machine of a digital-input amp
// Assumes: link clock and pins asynchronous to clk_sys_i, sampled twice
// Notes: slave serial control itself sits outside; this block gates it
`timescale 1ns/1ps
`include "asc_defs.svh"

module asc_standby_ctrl #(
    parameter int EN_W = `ASC_EN_WIDTH,
    parameter int SAMPLE_W = `ASC_SAMPLE_W,
    parameter int FIFO_DEPTH = `ASC_FIFO_DEPTH,
    parameter int BCLK_TIMEOUT = `ASC_BCLK_TIMEOUT_CYC,
    parameter int WS_TIMEOUT = `ASC_WS_TIMEOUT_BCLK
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [EN_W-1:0] enable_pins_i,
    input wire logic link_bclk_i,
    input wire logic link_ws_i,
    input wire logic link_sd_i,
    input wire logic pll_locked_i,
    input wire logic mute_n_i,
    input wire logic fault_open_load_i,
    input wire logic fault_short_i,
    input wire logic fault_thermal_i,
    input wire logic amp_ready_i,
    output asc_pkg::asc_state_t state_o,
    output logic [6:0] slave_addr_o,
    output logic slave_en_o,
    output logic regs_default_o,
    output logic amp_reset_o,
    output logic diag_irq_n_o,
    output logic muted_o,
    output logic [SAMPLE_W-1:0] sample_o,
    output logic sample_valid_o,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    import asc_pkg::*;

    localparam int BCW = $clog2(BCLK_TIMEOUT + 1);
    localparam int WSW = $clog2(WS_TIMEOUT + 1);
    localparam int SW = $clog2(SAMPLE_W + 1);

    typedef struct packed {
        logic [EN_W-1:0] en_s1, en_s2;
        logic [2:0] bclk_s1, bclk_s2, bclk_s3;
        logic ws_s1, ws_s2, sd_s1, sd_s2;
        logic lock_s1, lock_s2, mute_s1, mute_s2;
        logic [2:0] flt_s1, flt_s2;
        logic ws_prev;
        logic [BCW-1:0] bclk_idle;
        logic [WSW-1:0] ws_idle;
        logic [SW-1:0] bit_cnt;
        logic [SAMPLE_W-1:0] shreg;
        logic frame_ok;
        logic [4:0] settle;
        asc_state_t st;
        logic [6:0] addr;
        logic slave_en, regs_def, amp_rst, irq_n, muted;
        logic [SAMPLE_W-1:0] sample;
        logic [SAMPLE_W-1:0] cap;
        logic sample_v;
        logic cap_valid;
    } asc_st_t;

    asc_st_t s_q, s_d;
    logic bclk_rise, link_ok, en_legal, fifo_in_ready;
    logic fifo_out_valid;
    logic [SAMPLE_W-1:0] fifo_out_data;

    // bclk_s2 is the second synchroniser stage; edge taken from s2 vs s3
    assign bclk_rise = s_q.bclk_s2[0] && !s_q.bclk_s3[0];
    assign link_ok = (s_q.bclk_idle < BCW'(BCLK_TIMEOUT)) && s_q.frame_ok;
    // Only the low three enable bits pick the address; any nonzero is legal
    assign en_legal = |s_q.en_s2;
    assign state_o = s_q.st;
    assign slave_addr_o = s_q.addr;
    assign slave_en_o = s_q.slave_en;
    assign regs_default_o = s_q.regs_def;
    assign amp_reset_o = s_q.amp_rst;
    assign diag_irq_n_o = s_q.irq_n;
    assign muted_o = s_q.muted;
    assign sample_o = s_q.sample;
    assign sample_valid_o = s_q.sample_v;
    // The block never drives the control bus lines as master
    assign scl_oe_o = 1'b0;
    assign sda_oe_o = 1'b0;

    always_comb begin
        s_d = s_q;
        s_d.en_s1 = enable_pins_i;
        s_d.en_s2 = s_q.en_s1;
        s_d.bclk_s1 = {2'b00, link_bclk_i};
        s_d.bclk_s2 = s_q.bclk_s1;
        s_d.bclk_s3 = s_q.bclk_s2;
        s_d.ws_s1 = link_ws_i;
        s_d.ws_s2 = s_q.ws_s1;
        s_d.sd_s1 = link_sd_i;
        s_d.sd_s2 = s_q.sd_s1;
        s_d.lock_s1 = pll_locked_i;
        s_d.lock_s2 = s_q.lock_s1;
        s_d.mute_s1 = mute_n_i;
        s_d.mute_s2 = s_q.mute_s1;
        s_d.flt_s1 = {fault_thermal_i, fault_short_i, fault_open_load_i};
        s_d.flt_s2 = s_q.flt_s1;
        s_d.cap_valid = 1'b0;

        // Bit clock watchdog: a stalled clock means the stream is absent
        if (bclk_rise) begin
            s_d.bclk_idle = '0;
        end else if (s_q.bclk_idle < BCW'(BCLK_TIMEOUT)) begin
            s_d.bclk_idle = s_q.bclk_idle + 1'b1;
        end

        // Word select must toggle and frames must hold exactly SAMPLE_W bits
        if (bclk_rise) begin
            s_d.ws_prev = s_q.ws_s2;
            s_d.shreg = {s_q.shreg[SAMPLE_W-2:0], s_q.sd_s2};
            if (s_q.ws_s2 != s_q.ws_prev) begin
                s_d.ws_idle = '0;
                if (!s_q.ws_s2) begin
                    s_d.frame_ok = (s_q.bit_cnt == SW'(SAMPLE_W));
                    s_d.bit_cnt = SW'(1);
                    // Own holding word, so the output path cannot corrupt it
                    s_d.cap = s_q.shreg;
                    s_d.cap_valid = s_q.bit_cnt == SW'(SAMPLE_W);
                end else begin
                    s_d.bit_cnt = s_q.bit_cnt + 1'b1;
                end
            end else begin
                if (s_q.bit_cnt <= SW'(SAMPLE_W)) begin
                    s_d.bit_cnt = s_q.bit_cnt + 1'b1;
                end
                if (s_q.ws_idle < WSW'(WS_TIMEOUT)) begin
                    s_d.ws_idle = s_q.ws_idle + 1'b1;
                end else begin
                    s_d.frame_ok = 1'b0;
                end
            end
        end
        if (s_q.bclk_idle >= BCW'(BCLK_TIMEOUT)) begin
            s_d.frame_ok = 1'b0;
        end

        s_d.muted = !s_q.mute_s2;
        s_d.sample_v = fifo_out_valid && s_q.st == ASC_ACTIVE;
        // Next mute level, so a sample never leaves beside a stale flag
        if (fifo_out_valid) begin
            s_d.sample = s_d.muted ? '0 : fifo_out_data;
        end
        s_d.irq_n = !(|s_q.flt_s2);

        unique case (s_q.st)
            ASC_STANDBY: begin
                s_d.amp_rst = 1'b1;
                s_d.slave_en = 1'b0;
                s_d.regs_def = 1'b1;
                if (en_legal && link_ok) begin
                    s_d.addr = `ASC_ADDR_BASE | {4'h0, s_q.en_s2[2:0]};
                    s_d.st = ASC_WAIT_LINK;
                end
            end
            ASC_WAIT_LINK: begin
                if (!en_legal || !link_ok) begin
                    s_d.st = ASC_STANDBY;
                end else if (s_q.lock_s2) begin
                    s_d.settle = '0;
                    s_d.st = ASC_LOCKING;
                end
            end
            ASC_LOCKING: begin
                if (!en_legal || !link_ok || !s_q.lock_s2) begin
                    s_d.st = ASC_STANDBY;
                end else if (s_q.settle == 5'(`ASC_LOCK_SETTLE_CYC)) begin
                    s_d.st = ASC_ACTIVE;
                    s_d.amp_rst = 1'b0;
                    s_d.slave_en = 1'b1;
                    s_d.regs_def = 1'b1;
                end else begin
                    s_d.settle = s_q.settle + 1'b1;
                end
            end
            ASC_ACTIVE: begin
                // Defaults hold only until the first bus access
                if (amp_ready_i) s_d.regs_def = 1'b0;
                if (!en_legal) begin
                    s_d.st = ASC_STANDBY;
                    s_d.amp_rst = 1'b1;
                    s_d.slave_en = 1'b0;
                    s_d.regs_def = 1'b1;
                end else if (!s_q.lock_s2 || !link_ok) begin
                    s_d.st = ASC_STANDBY;
                    s_d.amp_rst = 1'b1;
                    s_d.slave_en = 1'b0;
                    s_d.regs_def = 1'b1;
                end
            end
            default: begin
                s_d.st = ASC_STANDBY;
                s_d.amp_rst = 1'b1;
                s_d.slave_en = 1'b0;
                s_d.regs_def = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.st <= ASC_STANDBY;
            s_q.amp_rst <= 1'b1;
            s_q.regs_def <= 1'b1;
            s_q.irq_n <= 1'b1;
            s_q.muted <= 1'b1;
            s_q.bclk_idle <= BCW'(BCLK_TIMEOUT);
        end else begin
            s_q <= s_d;
        end
    end

    // Samples buffered so the output side can pace itself; flushed in standby
    asc_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .flush_i(s_q.st != ASC_ACTIVE),
        .in_valid_i(s_q.cap_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(s_q.cap),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(amp_ready_i),
        .out_data_o(fifo_out_data)
    );
endmodule // asc_standby_ctrl

/* File: asc_standby_ctrl_bench.sv */
// Purpose: self-checking bench for the standby control block
// Assumes: inputs change 1 ns after the rising edge
// Notes: waits are bounded; a lapse shows as a state or sample valid mismatch
`timescale 1ns/1ps
module asc_standby_ctrl_bench;
    import asc_pkg::*;
    logic clk_sys_i = 0, reset_i = 1, pll_locked_i = 0, mute_n_i = 1;
    logic [3:0] enable_pins_i = 4'h0;
    logic fault_open_load_i = 0, fault_short_i = 0, fault_thermal_i = 0;
    logic amp_ready_i = 0, link_run = 0, link_bclk_i, link_ws_i, link_sd_i;
    asc_state_t state_o;
    logic [6:0] slave_addr_o;
    logic slave_en_o, regs_default_o, amp_reset_o, diag_irq_n_o, muted_o;
    logic [31:0] sample_o;
    logic sample_valid_o, scl_oe_o, sda_oe_o;
    int err_total = 0, n_compared = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    asc_link_src asc_link_src_i (.run_i(link_run), .bclk_o(link_bclk_i),
        .ws_o(link_ws_i), .sd_o(link_sd_i));
    asc_standby_ctrl asc_standby_ctrl_i (.clk_sys_i, .reset_i,
        .enable_pins_i, .link_bclk_i, .link_ws_i, .link_sd_i, .pll_locked_i,
        .mute_n_i, .fault_open_load_i, .fault_short_i, .fault_thermal_i,
        .amp_ready_i, .state_o, .slave_addr_o, .slave_en_o, .regs_default_o,
        .amp_reset_o, .diag_irq_n_o, .muted_o, .sample_o, .sample_valid_o,
        .scl_oe_o, .sda_oe_o);

    task automatic tick(int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_st(asc_state_t s, int lim);
        for (int i = 0; i < lim && state_o !== s; i++) tick(1);
        chk("state", 32'(s), 32'(state_o));
    endtask

    task automatic t_idle;
        chk("amp reset", 1, amp_reset_o);
        enable_pins_i = 4'h5;
        tick(300);
        chk("state no link", ASC_STANDBY, state_o);
        chk("slave en", 0, slave_en_o);
        $display("test idle done");
    endtask

    task automatic t_addr;
        link_run = 1;
        pll_locked_i = 1;
        for (int k = 1; k <= 8; k++) begin
            enable_pins_i = 4'(k);
            wait_st(ASC_ACTIVE, 2500);
            chk("addr", 32'(7'h68 | 7'(k & 7)), 32'(slave_addr_o));
            chk("regs default", 1, regs_default_o);
            enable_pins_i = 4'h0;
            wait_st(ASC_STANDBY, 10);
            chk("amp reset", 1, amp_reset_o);
        end
        $display("test address done");
    endtask

    task automatic t_loss;
        pll_locked_i = 0;
        enable_pins_i = 4'h3;
        tick(1500);
        chk("slave unlocked", 0, slave_en_o);
        pll_locked_i = 1;
        wait_st(ASC_ACTIVE, 100);
        amp_ready_i = 1;
        tick(1000);
        chk("regs after access", 0, regs_default_o);
        pll_locked_i = 0;
        wait_st(ASC_STANDBY, 10);
        pll_locked_i = 1;
        wait_st(ASC_ACTIVE, 2500);
        link_run = 0;
        wait_st(ASC_STANDBY, 700);
        link_run = 1;
        wait_st(ASC_ACTIVE, 2500);
        $display("test loss done");
    endtask

    task automatic t_mute;
        mute_n_i = 0;
        tick(5);
        chk("muted", 1, muted_o);
        for (int i = 0; i < 1000 && sample_valid_o !== 1; i++) tick(1);
        chk("sample valid", 1, sample_valid_o);
        chk("sample muted", 0, sample_o);
        mute_n_i = 1;
        tick(5);
        chk("unmuted", 0, muted_o);
        for (int i = 0; i < 1000 && sample_valid_o !== 1; i++) tick(1);
        chk("play valid", 1, sample_valid_o);
        chk("play nonzero", 1, 32'(sample_o != 0));
        $display("test mute done");
    endtask

    task automatic t_fault;
        for (int k = 0; k < 3; k++) begin
            {fault_thermal_i, fault_short_i, fault_open_load_i} = 3'(1 << k);
            tick(5);
            chk("irq set", 0, diag_irq_n_o);
            {fault_thermal_i, fault_short_i, fault_open_load_i} = 3'h0;
            tick(5);
            chk("irq clear", 1, diag_irq_n_o);
        end
        $display("test fault done");
    endtask

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #200_000;
        err_total++;
        finish_test();
    end

    initial begin
        tick(3);
        reset_i = 0;
        t_idle();
        t_addr();
        t_loss();
        t_mute();
        t_fault();
        finish_test();
    end
endmodule // asc_standby_ctrl_bench
